// File: common/nvm_ctl_pkg.sv
// Operation
// - Unlock opens control for one write only.
// - Key register is write only, reads zero.
// - Start bit 15 set by software, hardware clears.
// - Abort bit 13 set on early termination.
// - Skip bit 12 suppresses automatic pre-erase.
// - Codes 011010/011001/011000 erase eight/four/one words.
// - Code 0100xx erases whole memory.
// - Program code writes one latched word.
// - Operations run without stalling the bus.
// - Table write address captured and used.
// - High register upper 8, low lower 16.
// - Captured address not bus mapped.
// - Low address bit 0 always zero.
// - High address bit 7 always zero.
// - Memory window 7FFE00h-7FFFFFh, 256 words.
// - Erase bit selects erase or program meaning.
// - Undefined codes perform no operation.
// - Completion sets the completion flag.
`default_nettype none
package nvm_ctl_pkg;
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_KEY        = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'hAA;
  localparam int          BIT_START      = 15;
  localparam int          BIT_ALLOW      = 14;
  localparam int          BIT_ABORT      = 13;
  localparam int          BIT_SKIP       = 12;
  localparam int          BIT_ERASE      = 6;
  localparam int          BIT_DONE_FLAG  = 0;
  localparam int          BIT_BUSY       = 1;
  localparam logic [5:0]  CODE_ERASE8    = 6'h1A;
  localparam logic [5:0]  CODE_ERASE4    = 6'h19;
  localparam logic [5:0]  CODE_ERASE1    = 6'h18;
  localparam logic [3:0]  CODE_BULK_HI   = 4'h4;
  localparam logic [3:0]  CODE_PROG_HI   = 4'h1;
  localparam logic [23:0] MEM_FIRST_ADDR = 24'h7FFE00;
  localparam logic [23:0] MEM_LAST_ADDR  = 24'h7FFFFF;
  localparam int          MEM_WORDS      = 256;
  localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          ERASE_TIME_NS  = 4000000;
  localparam int          PROG_TIME_NS   = 4000000;
  localparam int          ERASE_CYCLES   = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int          PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       start;
    logic       allow;
    logic       abort;
    logic       skip;
    logic       erase;
    logic [5:0] opSel;
  } ctl_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_ERASE1, OP_ERASE4, OP_ERASE8, OP_BULK, OP_PROG
  } op_kind_t;
endpackage : nvm_ctl_pkg
`default_nettype wire

// File: logic/nvm_op_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module nvm_op_ctl #(
  parameter int ERASE_CNT = nvm_ctl_pkg::ERASE_CYCLES,
  parameter int PROG_CNT  = nvm_ctl_pkg::PROG_CYCLES,
  parameter int CNT_W     = 24
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Table write side and word read port
  input  wire logic                 tblWrValid,
  input  wire logic [23:0]          tblWrAddr,
  input  wire logic [15:0]          tblWrData,
  input  wire logic [7:0]           rdIndex,
  output logic [15:0]               rdData,
  // Early termination by pin or watchdog reset
  input  wire logic                 opAbortReq,
  // Status
  output logic [7:0]                capturedAddressHigh,
  output logic [15:0]               capturedAddressLow,
  output logic                      busy,
  output logic                      completionIrqFlag,
  output nvm_ctl_pkg::ctl_t         controlState
);
  import nvm_ctl_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} state_t;

  function automatic op_kind_t decodeOp(input logic erase, input logic [5:0] sel);
    op_kind_t k;
    k = OP_NONE;
    if (erase) begin
      if (sel == CODE_ERASE8) k = OP_ERASE8;
      else if (sel == CODE_ERASE4) k = OP_ERASE4;
      else if (sel == CODE_ERASE1) k = OP_ERASE1;
      else if (sel[5:2] == CODE_BULK_HI) k = OP_BULK;
    end else if (sel[5:2] == CODE_PROG_HI) begin
      k = OP_PROG;
    end
    return k;
  endfunction : decodeOp

  logic [15:0] mem [MEM_WORDS];
  ctl_t        ctl_r;
  state_t      state_r;
  op_kind_t    kind_r;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0]  adrHigh_r;
  logic [15:0] adrLow_r;
  logic [15:0] latch_r;
  logic [7:0]  opIdx_r;
  logic [15:0] opData_r;
  logic        keyHalf_r;
  logic        unlockOpen_r;
  logic        doneFlag_r;
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  logic [31:0] hrdata_r;
  logic [15:0] rdData_r;

  // Bus decode; the slave never inserts wait states, so control stays responsive.
  wire logic        addrPhase = hsel & htrans[1] & hready;
  wire logic        wrCtl     = wrPend_r & (wrAddr_r == OFS_CONTROL);
  wire logic        wrKey     = wrPend_r & (wrAddr_r == OFS_KEY);
  wire logic        wrStat    = wrPend_r & (wrAddr_r == OFS_STATUS);
  wire ctl_t        ctlWr     = ctl_t'({hwdata[15:12], hwdata[6:0]});
  wire op_kind_t    wrKind    = decodeOp(ctlWr.erase, ctlWr.opSel);
  wire logic        idle      = (state_r == ST_IDLE);
  wire logic        startOk   = wrCtl & idle & ctlWr.start & unlockOpen_r & ctlWr.allow
                                & (wrKind != OP_NONE);
  wire logic        cntDone   = (cnt_r == '0);
  wire logic        opEnd     = ~idle & cntDone & ~opAbortReq
                                & ((state_r == ST_PROG) | (kind_r != OP_PROG));
  wire logic        opKill    = ~idle & opAbortReq;
  wire logic [7:0]  curIdx    = adrLow_r[8:1];
  wire logic [15:0] ctlRead   = {ctl_r.start, ctl_r.allow, ctl_r.abort, ctl_r.skip,
                                 5'h00, ctl_r.erase, ctl_r.opSel};
  wire logic [31:0] rdMux     = (haddr[7:0] == OFS_CONTROL) ? {16'h0000, ctlRead} :
                                (haddr[7:0] == OFS_STATUS)  ?
                                  {30'h00000000, ~idle, doneFlag_r} :
                                  32'h00000000;
  wire logic [7:0]  eraseMask = (kind_r == OP_ERASE8) ? 8'hF8 :
                                (kind_r == OP_ERASE4) ? 8'hFC : 8'hFF;

  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = hrdata_r;
  assign rdData              = rdData_r;
  assign capturedAddressHigh = adrHigh_r;
  assign capturedAddressLow  = adrLow_r;
  assign busy                = ~idle;
  assign completionIrqFlag   = doneFlag_r;
  assign controlState        = ctl_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wrPend_r <= addrPhase & hwrite;
      wrAddr_r <= haddr[7:0];
      if (addrPhase & ~hwrite) hrdata_r <= rdMux;
    end
  end

  // Table writes load the captured address and the data latch directly.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adrHigh_r <= 8'h00;
      adrLow_r  <= 16'h0000;
      latch_r   <= 16'h0000;
    end else if (tblWrValid) begin
      adrHigh_r <= {1'b0, tblWrAddr[22:16]};
      adrLow_r  <= {tblWrAddr[15:1], 1'b0};
      latch_r   <= tblWrData;
    end
  end

  // Any write closes the unlock window; only the second key right after the first opens it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyHalf_r    <= 1'b0;
      unlockOpen_r <= 1'b0;
    end else if (wrPend_r) begin
      keyHalf_r    <= wrKey & (hwdata[7:0] == KEY_FIRST);
      unlockOpen_r <= wrKey & keyHalf_r & (hwdata[7:0] == KEY_SECOND);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= ctl_t'(11'h000);
    end else if (opEnd) begin
      ctl_r.start <= 1'b0;
      ctl_r.allow <= 1'b0;
      ctl_r.abort <= 1'b0;
    end else if (opKill) begin
      ctl_r.start <= 1'b0;
      ctl_r.abort <= 1'b1;
    end else if (wrCtl & idle) begin
      ctl_r       <= ctlWr;
      ctl_r.start <= startOk;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      doneFlag_r <= 1'b0;
    end else if (opEnd) begin
      doneFlag_r <= 1'b1;
    end else if (wrStat & hwdata[BIT_DONE_FLAG]) begin
      doneFlag_r <= 1'b0;
    end
  end

  // The cycle is self-timed and leaves the bus free throughout.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      kind_r   <= OP_NONE;
      cnt_r    <= '0;
      opIdx_r  <= 8'h00;
      opData_r <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (startOk) begin
            kind_r   <= wrKind;
            opIdx_r  <= curIdx;
            opData_r <= latch_r;
            if ((wrKind == OP_PROG) && ctlWr.skip) begin
              state_r <= ST_PROG;
              cnt_r   <= CNT_W'(PROG_CNT - 1);
            end else begin
              state_r <= ST_ERASE;
              cnt_r   <= CNT_W'(ERASE_CNT - 1);
            end
          end
        end
        ST_ERASE: begin
          if (opKill || opEnd) begin
            state_r <= ST_IDLE;
          end else if (cntDone) begin
            state_r <= ST_PROG;
            cnt_r   <= CNT_W'(PROG_CNT - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_PROG: begin
          if (opKill || opEnd) state_r <= ST_IDLE;
          else cnt_r <= cnt_r - 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Contents change only when a phase completes; an aborted phase leaves them alone.
  always_ff @(posedge core_clk) begin
    rdData_r <= mem[rdIndex];
    if ((state_r == ST_ERASE) && cntDone && !opAbortReq) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        if ((kind_r == OP_BULK) || ((8'(i) & eraseMask) == (opIdx_r & eraseMask))) begin
          mem[i] <= ERASED_WORD;
        end
      end
    end
    if ((state_r == ST_PROG) && cntDone && !opAbortReq) begin
      mem[opIdx_r] <= opData_r;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_start_needs_unlock: assert property (
    wrCtl && idle && hwdata[BIT_START] && !unlockOpen_r |=> !ctl_r.start && idle)
    else $error("start accepted without unlock");
  chk_unlock_one_shot: assert property (
    unlockOpen_r && wrPend_r |=> !unlockOpen_r)
    else $error("unlock window outlived one write");
  chk_key_order: assert property (
    $rose(unlockOpen_r) |-> $past(keyHalf_r) && $past(wrKey))
    else $error("unlock opened without ordered keys");
  chk_key_reads_zero: assert property (
    addrPhase && !hwrite && haddr[7:0] == OFS_KEY |=> hrdata == 32'h00000000)
    else $error("key register read nonzero");
  chk_end_clears_bits: assert property (
    opEnd |=> !ctl_r.start && !ctl_r.allow && !busy && doneFlag_r)
    else $error("completion did not clear start and allow");
  chk_busy_with_start: assert property (
    busy |-> ctl_r.start)
    else $error("busy without start bit");
  chk_abort_flag: assert property (
    opKill |=> ctl_r.abort && !busy)
    else $error("abort not flagged");
  chk_unimpl_zero: assert property (
    addrPhase && !hwrite && haddr[7:0] == OFS_CONTROL |=> hrdata[11:7] == 5'h00)
    else $error("unimplemented bits nonzero");
  chk_addr_even: assert property (
    tblWrValid |=> !capturedAddressLow[0] && !capturedAddressHigh[7])
    else $error("captured address bounds broken");
  chk_bad_code_nop: assert property (
    wrCtl && idle && unlockOpen_r && wrKind == OP_NONE |=> !busy)
    else $error("undefined code started");
  chk_auto_erase: assert property (
    startOk && wrKind == OP_PROG && !ctlWr.skip |=> state_r == ST_ERASE)
    else $error("program skipped automatic erase");

  // Each operation kind except the one-word erase is checked on its own so that a decode slip is seen at once.
  chk_start_launches: assert property (
    startOk |=> busy && ctl_r.start)
    else $error("accepted start did not launch");
  chk_start_only_busy: assert property (
    ctl_r.start |-> busy)
    else $error("start bit set while idle");
  chk_allow_required: assert property (
    wrCtl && idle && unlockOpen_r && ctlWr.start && !ctlWr.allow |=> !busy)
    else $error("start accepted without allow bit");
  chk_busy_locks_ctl: assert property (
    wrCtl && busy && !opEnd && !opKill |=> ctl_r == $past(ctl_r))
    else $error("control changed by a write while busy");
  chk_skip_prog_only: assert property (
    startOk && wrKind == OP_PROG && ctlWr.skip |=> state_r == ST_PROG)
    else $error("program with skip did not go straight to program");
  chk_erase_eight: assert property (
    startOk && ctlWr.erase && ctlWr.opSel == CODE_ERASE8 |=> kind_r == OP_ERASE8)
    else $error("eight word erase not selected");
  chk_erase_four: assert property (
    startOk && ctlWr.erase && ctlWr.opSel == CODE_ERASE4 |=> kind_r == OP_ERASE4)
    else $error("four word erase not selected");
  chk_bulk_select: assert property (
    startOk && ctlWr.erase && ctlWr.opSel[5:2] == CODE_BULK_HI |=> kind_r == OP_BULK)
    else $error("bulk erase not selected");
  chk_prog_select: assert property (
    startOk && !ctlWr.erase |=> kind_r == OP_PROG)
    else $error("program not selected with erase bit clear");
  chk_abort_keeps_allow: assert property (
    opKill && ctl_r.allow |=> ctl_r.allow)
    else $error("abort cleared the allow bit");
  chk_kill_no_done: assert property (
    opKill && !doneFlag_r |=> !completionIrqFlag)
    else $error("aborted operation raised completion");

  cov_prog_done: cover property (opEnd && kind_r == OP_PROG);
  cov_bulk_done: cover property (opEnd && kind_r == OP_BULK);
  cov_aborted:   cover property (opKill);
  cov_locked:    cover property (wrCtl && hwdata[BIT_START] && !unlockOpen_r);
  cov_erase8_done: cover property (opEnd && kind_r == OP_ERASE8);
endmodule : nvm_op_ctl
`default_nettype wire

// File: bench/core_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_side_model (
  // Clock
  input  wire logic        core_clk,
  // Table write and early termination
  output logic             tblWrValid,
  output logic [23:0]      tblWrAddr,
  output logic [15:0]      tblWrData,
  output logic             opAbortReq
);
  initial begin
    tblWrValid = 1'b0;
    tblWrAddr  = 24'h000000;
    tblWrData  = 16'h0000;
    opAbortReq = 1'b0;
  end
  // Address and data are inverted after the pulse so stale values are never mistaken for live ones.
  task automatic tblwr(input logic [23:0] a, input logic [15:0] d);
    tblWrValid <= 1'b1;
    tblWrAddr  <= a;
    tblWrData  <= d;
    @(posedge core_clk);
    tblWrValid <= 1'b0;
    tblWrAddr  <= ~a;
    tblWrData  <= ~d;
  endtask : tblwr
  task automatic resetPulse();
    opAbortReq <= 1'b1;
    @(posedge core_clk);
    opAbortReq <= 1'b0;
  endtask : resetPulse
endmodule : core_side_model
`default_nettype wire

// File: bench/tb_eeprom_program_erase_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_eeprom_program_erase_control;
  import nvm_ctl_pkg::*;
  logic        core_clk, hreadyout, hresp, busy, cFlag, tblWrValid, opAbortReq;
  logic        rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [23:0] tblWrAddr;
  logic [15:0] tblWrData, rdData, capLo;
  logic [7:0]  rdIndex = 8'h00, capHi;
  ctl_t        ctl;
  logic [15:0] model [256];
  int          nFail, testsRun, seed;

  nvm_op_ctl #(.ERASE_CNT(6), .PROG_CNT(5)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tblWrValid(tblWrValid), .tblWrAddr(tblWrAddr), .tblWrData(tblWrData),
    .rdIndex(rdIndex), .rdData(rdData), .opAbortReq(opAbortReq),
    .capturedAddressHigh(capHi), .capturedAddressLow(capLo), .busy(busy),
    .completionIrqFlag(cFlag), .controlState(ctl));
  core_side_model core (.core_clk(core_clk), .tblWrValid(tblWrValid), .tblWrAddr(tblWrAddr),
    .tblWrData(tblWrData), .opAbortReq(opAbortReq));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic testDone();
    $display("compares %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : testDone
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    testsRun++;
    if (s !== e) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic busx(input logic [31:0] a, input logic [31:0] d, input logic w);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsel   <= 1'b1;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : busx
  task automatic bw(input logic [31:0] a, input logic [31:0] d);
    busx(a, d, 1'b1);
  endtask : bw
  task automatic br(input logic [31:0] a);
    busx(a, 32'h0, 1'b0);
  endtask : br
  task automatic chkMem();
    for (int i = 0; i < 256; i++) begin
      @(posedge core_clk);
      rdIndex <= 8'(i);
      @(posedge core_clk);
      #1;
      cmp("memWord", model[i], rdData);
    end
    @(posedge core_clk);
  endtask : chkMem
  // Mode m: 0 normal, 1 reset mid-cycle, 2 broken key pair, 3 window spent elsewhere, 4 no allow.
  task automatic runOp(input logic [5:0] c, input logic e, s, input logic [7:0] x, input int m);
    logic [15:0] d;
    logic        ok;
    int          n;
    d  = 16'($random(seed));
    ok = e ? (c inside {CODE_ERASE8, CODE_ERASE4, CODE_ERASE1} || c[5:2] == CODE_BULK_HI)
           : c[5:2] == CODE_PROG_HI;
    core.tblwr({8'hFF, 7'h7F, x, 1'b1}, d);
    bw(32'(OFS_KEY), 32'(KEY_FIRST));
    if (m == 2) bw(32'(OFS_KEY), 32'h33);
    bw(32'(OFS_KEY), 32'(KEY_SECOND));
    if (m == 3) bw(32'(OFS_CONTROL), 32'h4000);
    cmp("capHigh", 8'h7F, capHi);
    cmp("capLow", {7'h7F, x, 1'b0}, capLo);
    bw(32'(OFS_CONTROL), {16'h0, 1'b1, 1'(m != 4), 1'b0, s, 5'h0, e, c});
    ok = ok && m != 2 && m != 3 && m != 4;
    if (m == 1 && ok) core.resetPulse();
    #1;
    cmp("busy", ok && m != 1, busy);
    cmp("start", ok && m != 1, ctl.start);
    cmp("readyOut", 32'h1, hreadyout);
    cmp("resp", 32'h0, hresp);
    @(posedge core_clk);
    if (ok && m == 0) bw(32'(OFS_CONTROL), 32'h0);
    n = 0;
    do begin
      br(32'(OFS_STATUS));
      n++;
    end while (rv[BIT_BUSY] === 1'b1 && n < 100);
    cmp("ctlEnd", {1'b0, !(ok && m != 1) && m != 4, ok && m == 1, s, e, c}, ctl);
    cmp("doneFlag", ok && m != 1, cFlag);
    bw(32'(OFS_STATUS), 32'h1);
    br(32'(OFS_STATUS));
    cmp("statusClr", 32'h0, rv);
    bw(32'(OFS_CONTROL), 32'h0);
    if (ok && m != 1) begin
      n = c == CODE_ERASE8 ? 8 : c == CODE_ERASE4 ? 4 : 1;
      for (int i = 0; i < 256; i++)
        if (e && (c[5:2] == CODE_BULK_HI || i / n == x / n)) model[i] = ERASED_WORD;
      if (!e) model[x] = d;
    end
    chkMem();
  endtask : runOp

  initial begin
    #2500000;
    nFail++;
    testDone();
  end
  initial begin
    seed = 32'hf31e;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    br(32'(OFS_CONTROL));
    cmp("ctlReset", 32'(CONTROL_RESET), rv);
    br(32'(OFS_KEY));
    cmp("keyRead", 32'h0, rv);
    br(32'h0C);
    cmp("unmapped", 32'h0, rv);
    bw(32'(OFS_CONTROL), 32'hFFFFFFFF);
    br(32'(OFS_CONTROL));
    cmp("ctlBits", 32'h707F, rv);
    bw(32'(OFS_CONTROL), 32'h0);
    runOp({CODE_BULK_HI, 2'($random(seed))}, 1'b1, 1'b0, 8'h00, 0);
    runOp(6'h04, 1'b0, 1'b1, 8'hFF, 0);
    for (int i = 0; i < 3; i++) runOp({4'h1, 2'($random(seed))}, 1'b0, 1'b0, 8'(3 + 5 * i), 0);
    runOp(CODE_ERASE1, 1'b1, 1'b0, 8'h03, 0);
    runOp(CODE_ERASE4, 1'b1, 1'b0, 8'h09, 0);
    runOp(CODE_ERASE8, 1'b1, 1'b0, 8'h0E, 0);
    runOp(6'h1B, 1'b1, 1'b0, 8'h20, 0);
    runOp(6'h05, 1'b1, 1'b0, 8'h20, 0);
    runOp(6'h04, 1'b0, 1'b0, 8'h21, 1);
    runOp(6'h04, 1'b0, 1'b0, 8'h22, 2);
    runOp(6'h04, 1'b0, 1'b0, 8'h23, 3);
    runOp(6'h04, 1'b0, 1'b0, 8'h24, 4);
    testDone();
  end
endmodule : tb_eeprom_program_erase_control
`default_nettype wire
